// File: shared/psw_pkg.sv
// Operation
// - Optional top 32 Kbyte data window onto one 32K-word program page
// - Window used only when address top bit and control bit 2 are set
// - Eight-bit page register selects one of 256 program pages
// - Program address is page on top, low 15 address bits below
// - Low 15 data address bits map one-to-one onto program address bits
// - Window read adds zero to two cycles; two program fetches when it adds any
// - Only the low 16 bits of the 24-bit program word return
// - Window access waits while a table read or write is busy
// - Outside repeat: word or double moves add one cycle, others add two
// - Repeat first, last and interrupt edges add two; other iterations none
`default_nettype none
package psw_pkg;
  // ------------------------------------------------------------
  // Widths and bit positions
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned PAGE_W = 8;
  localparam int unsigned OFS_W = 15;
  localparam int unsigned PWORD_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned VIEW_EN_BIT = 2;
  localparam int unsigned VIEW_SEL_BIT = 15;
  localparam int unsigned CNT_W = 3;

  // ------------------------------------------------------------
  // Added cycles and reset values
  // ------------------------------------------------------------
  localparam logic [CNT_W-1:0] EXTRA_NONE = 3'h0;
  localparam logic [CNT_W-1:0] EXTRA_MOVE = 3'h1;
  localparam logic [CNT_W-1:0] EXTRA_OTHER = 3'h2;
  localparam logic [CNT_W-1:0] EXTRA_REP_EDGE = 3'h2;
  localparam logic [CNT_W-1:0] EXTRA_REP_MID = 3'h0;
  localparam logic [CNT_W-1:0] BASE_WAIT = 3'h1;
  localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;
  localparam logic [ADDR_W-1:0] RST_ADDR = 16'h0000;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PSW_KIND_MOVE,
    PSW_KIND_DOUBLE_MOVE,
    PSW_KIND_OTHER
  } psw_kind_t;

  typedef struct packed {
    logic [ADDR_W-1:0] effective_address;
    psw_kind_t kind;
    logic in_repeat;
    logic rep_first;
    logic rep_last;
    logic rep_irq_edge;
  } psw_req_t;

  typedef enum logic [1:0] {
    PSW_ST_IDLE,
    PSW_ST_TBL_WAIT,
    PSW_ST_RUN
  } psw_state_t;
endpackage
`default_nettype wire

// File: hw/psw_cost.sv
`timescale 1ns/1ps
`default_nettype none
module psw_cost
  import psw_pkg::*;
(
  input wire psw_req_t info,
  input wire logic view,
  output logic [CNT_W-1:0] extra
);
  always_comb begin
    extra = EXTRA_NONE;
    if (!view) begin
      extra = EXTRA_NONE;
    end else if (info.in_repeat) begin
      if (info.rep_first || info.rep_last || info.rep_irq_edge) begin
        extra = EXTRA_REP_EDGE;
      end else begin
        extra = EXTRA_REP_MID;
      end
    end else if (info.kind == PSW_KIND_MOVE || info.kind == PSW_KIND_DOUBLE_MOVE) begin
      extra = EXTRA_MOVE;
    end else begin
      extra = EXTRA_OTHER;
    end
  end
endmodule // psw_cost
`default_nettype wire

// File: hw/psw_window.sv
`timescale 1ns/1ps
`default_nettype none
module psw_window
  import psw_pkg::*;
#(
  parameter int unsigned PAGE_BITS = PAGE_W
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic RD_REQ,
  input wire psw_req_t RD_INFO,
  input wire logic [CTRL_W-1:0] CPU_CONTROL_REG,
  input wire logic [PAGE_BITS-1:0] VIEW_PAGE_SELECT,
  input wire logic TABLE_BUSY,
  input wire logic [PWORD_W-1:0] PM_RDATA,
  input wire logic [DATA_W-1:0] DM_RDATA,
  output logic PM_REQ,
  output logic [PAGE_BITS+OFS_W-1:0] PM_ADDR,
  output logic DM_REQ,
  output logic [ADDR_W-1:0] DM_ADDR,
  output logic RD_DONE,
  output logic [DATA_W-1:0] RD_DATA,
  output logic BUSY,
  output logic VIEW_HIT
);
  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (PAGE_BITS == 0 || PAGE_BITS > PAGE_W) begin : g_bad_page
    $error("page width out of range");
  end

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------
  psw_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic is_view, next_is_view;
  logic two_fetch, next_two_fetch;
  logic req1, next_req1;
  logic resp, next_resp;
  logic [DATA_W-1:0] held, next_held;
  logic [ADDR_W-1:0] lat_addr, next_lat_addr;
  logic [CNT_W-1:0] lat_extra, next_lat_extra;
  logic next_pm_req, next_dm_req, next_rd_done, next_busy, next_view_hit;
  logic [PAGE_BITS+OFS_W-1:0] next_pm_addr;
  logic [ADDR_W-1:0] next_dm_addr;
  logic [DATA_W-1:0] next_rd_data;
  logic [CNT_W-1:0] extra_in;
  logic view_in;
  logic take;
  logic start;
  logic [ADDR_W-1:0] s_addr;
  logic [CNT_W-1:0] s_extra;
  logic s_view;

  assign view_in = RD_INFO.effective_address[VIEW_SEL_BIT] && CPU_CONTROL_REG[VIEW_EN_BIT];
  assign take = RD_REQ && (state == PSW_ST_IDLE);

  psw_cost u_cost (
    .info(RD_INFO),
    .view(view_in),
    .extra(extra_in)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_is_view = is_view;
    next_two_fetch = two_fetch;
    next_lat_addr = lat_addr;
    next_lat_extra = lat_extra;
    next_busy = BUSY;
    next_view_hit = VIEW_HIT;
    next_rd_done = 1'b0;
    next_rd_data = RD_DATA;
    next_pm_addr = PM_ADDR;
    next_dm_addr = DM_ADDR;
    next_req1 = 1'b0;
    next_resp = req1;
    next_held = resp ? (is_view ? PM_RDATA[DATA_W-1:0] : DM_RDATA) : held;
    start = 1'b0;
    s_addr = RD_INFO.effective_address;
    s_extra = extra_in;
    s_view = view_in;
    case (state)
      PSW_ST_IDLE: begin
        if (RD_REQ) begin
          next_lat_addr = RD_INFO.effective_address;
          next_lat_extra = extra_in;
          next_busy = 1'b1;
          if (view_in && TABLE_BUSY) begin
            next_state = PSW_ST_TBL_WAIT;
          end else begin
            start = 1'b1;
          end
        end
      end
      PSW_ST_TBL_WAIT: begin
        s_addr = lat_addr;
        s_extra = lat_extra;
        s_view = 1'b1;
        if (!TABLE_BUSY) begin
          start = 1'b1;
        end
      end
      PSW_ST_RUN: begin
        if (cnt == EXTRA_NONE) begin
          next_state = PSW_ST_IDLE;
          next_busy = 1'b0;
          next_rd_done = 1'b1;
          next_rd_data = next_held;
        end else begin
          next_cnt = CNT_W'(cnt - BASE_WAIT);
        end
      end
      default: begin
        next_state = PSW_ST_IDLE;
      end
    endcase
    if (start) begin
      next_state = PSW_ST_RUN;
      next_cnt = CNT_W'(s_extra + BASE_WAIT);
      next_is_view = s_view;
      next_two_fetch = s_view && (s_extra != EXTRA_NONE);
      next_view_hit = s_view;
      next_req1 = 1'b1;
      // program address formed from page and offset
      if (s_view) begin
        next_pm_addr = {VIEW_PAGE_SELECT, s_addr[OFS_W-1:0]};
      end else begin
        next_dm_addr = s_addr;
      end
    end
    next_dm_req = start && !s_view;
    next_pm_req = (start && s_view) || (req1 && is_view && two_fetch);
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      state <= PSW_ST_IDLE;
      cnt <= EXTRA_NONE;
      is_view <= 1'b0;
      two_fetch <= 1'b0;
      req1 <= 1'b0;
      resp <= 1'b0;
      held <= RST_DATA;
      lat_addr <= RST_ADDR;
      lat_extra <= EXTRA_NONE;
      PM_REQ <= 1'b0;
      PM_ADDR <= '0;
      DM_REQ <= 1'b0;
      DM_ADDR <= RST_ADDR;
      RD_DONE <= 1'b0;
      RD_DATA <= RST_DATA;
      BUSY <= 1'b0;
      VIEW_HIT <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      is_view <= next_is_view;
      two_fetch <= next_two_fetch;
      req1 <= next_req1;
      resp <= next_resp;
      held <= next_held;
      lat_addr <= next_lat_addr;
      lat_extra <= next_lat_extra;
      PM_REQ <= next_pm_req;
      PM_ADDR <= next_pm_addr;
      DM_REQ <= next_dm_req;
      DM_ADDR <= next_dm_addr;
      RD_DONE <= next_rd_done;
      RD_DATA <= next_rd_data;
      BUSY <= next_busy;
      VIEW_HIT <= next_view_hit;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  logic direct;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] pm_low;
  logic [PAGE_BITS-1:0] page_in;
  assign direct = take && view_in && !TABLE_BUSY;
  assign req_addr = RD_INFO.effective_address;
  assign pm_low = PM_RDATA[DATA_W-1:0];
  assign page_in = VIEW_PAGE_SELECT;

  sequence s_done0;
    ##1 !RD_DONE [*2] ##1 RD_DONE;
  endsequence
  sequence s_done1;
    ##1 !RD_DONE [*3] ##1 RD_DONE;
  endsequence
  sequence s_done2;
    ##1 !RD_DONE [*4] ##1 RD_DONE;
  endsequence

  chk_enable_gate: assert property (
    take && req_addr[VIEW_SEL_BIT] && !CPU_CONTROL_REG[VIEW_EN_BIT] |=> DM_REQ && !PM_REQ)
    else $error("window used while disabled");
  chk_view_route: assert property (
    direct |=> PM_REQ && !DM_REQ && VIEW_HIT)
    else $error("window read not sent to program memory");
  chk_page_bits: assert property (
    direct |=> PM_ADDR[PAGE_BITS+OFS_W-1:OFS_W] == $past(page_in))
    else $error("page bits wrong");
  chk_offset_map: assert property (
    direct |=> PM_ADDR[OFS_W-1:0] == $past(req_addr[OFS_W-1:0]))
    else $error("offset bits wrong");
  chk_two_fetch: assert property (
    direct && extra_in != EXTRA_NONE |=> PM_REQ [*2] ##1 !PM_REQ)
    else $error("second fetch missing");
  chk_low_word: assert property (
    direct && extra_in == EXTRA_NONE |-> ##3 RD_DATA == $past(pm_low))
    else $error("returned data not the low word");
  chk_plain_read: assert property (
    take && !view_in |-> s_done0 ##0 !VIEW_HIT)
    else $error("plain read timing wrong");
  chk_table_hold: assert property (
    state == PSW_ST_TBL_WAIT && TABLE_BUSY |=> !PM_REQ && BUSY)
    else $error("window fetch during table access");
  chk_move_cost: assert property (
    direct && !RD_INFO.in_repeat
    && (RD_INFO.kind == PSW_KIND_MOVE || RD_INFO.kind == PSW_KIND_DOUBLE_MOVE) |-> s_done1)
    else $error("move cost wrong");
  chk_other_cost: assert property (
    direct && !RD_INFO.in_repeat && RD_INFO.kind == PSW_KIND_OTHER |-> s_done2)
    else $error("other cost wrong");
  chk_rep_mid: assert property (
    direct && RD_INFO.in_repeat && !RD_INFO.rep_first && !RD_INFO.rep_last
    && !RD_INFO.rep_irq_edge |-> s_done0)
    else $error("repeat middle cost wrong");
  chk_rep_edge: assert property (
    direct && RD_INFO.in_repeat && (RD_INFO.rep_first || RD_INFO.rep_last
    || RD_INFO.rep_irq_edge) |-> s_done2)
    else $error("repeat edge cost wrong");
endmodule // psw_window
`default_nettype wire

// File: sim/psw_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module psw_mem_model
  import psw_pkg::*;
(
  input wire logic clock,
  input wire logic pm_req,
  input wire logic [PAGE_W+OFS_W-1:0] pm_addr,
  input wire logic dm_req,
  input wire logic [ADDR_W-1:0] dm_addr,
  output logic [PWORD_W-1:0] pm_rdata,
  output logic [DATA_W-1:0] dm_rdata
);
  // upper byte all ones or zeros
  // Stale words are inverted so a sample one cycle late never matches
  always @(posedge clock) begin
    if (pm_req) begin
      pm_rdata <= {{8{pm_addr[3]}}, pm_addr[15:0] ^ {pm_addr[22:15], 8'h5a}};
    end else begin
      pm_rdata <= ~pm_rdata;
    end
    if (dm_req) begin
      dm_rdata <= dm_addr ^ 16'hc3a5;
    end else begin
      dm_rdata <= ~dm_rdata;
    end
  end
endmodule // psw_mem_model
`default_nettype wire

// File: sim/program_space_data_window_tb.sv
`timescale 1ns/1ps
`default_nettype none
module program_space_data_window_tb
  import psw_pkg::*;
;
  typedef struct {
    logic [15:0] data;
    logic [22:0] addr;
    logic view;
    int due;
    int npm;
  } psw_exp_t;
  logic clock, rst_n, rd_req, table_busy, pm_req, dm_req, rd_done, busy, view_hit;
  psw_req_t rd_info;
  logic [15:0] cpu_control_reg, dm_rdata, dm_addr, rd_data;
  logic [7:0] view_page_select;
  logic [23:0] pm_rdata;
  logic [22:0] pm_addr;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int pm_n = 0;
  int dm_n = 0;
  psw_exp_t q[$];

  psw_window u_psw_window (
    .CLOCK(clock), .RST_N(rst_n), .RD_REQ(rd_req), .RD_INFO(rd_info),
    .CPU_CONTROL_REG(cpu_control_reg), .VIEW_PAGE_SELECT(view_page_select),
    .TABLE_BUSY(table_busy), .PM_RDATA(pm_rdata), .DM_RDATA(dm_rdata),
    .PM_REQ(pm_req), .PM_ADDR(pm_addr), .DM_REQ(dm_req), .DM_ADDR(dm_addr),
    .RD_DONE(rd_done), .RD_DATA(rd_data), .BUSY(busy), .VIEW_HIT(view_hit));
  psw_mem_model u_psw_mem_model (
    .clock(clock), .pm_req(pm_req), .pm_addr(pm_addr), .dm_req(dm_req),
    .dm_addr(dm_addr), .pm_rdata(pm_rdata), .dm_rdata(dm_rdata));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Ceiling sits well above the longest expected run
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ------
  // Monitor
  // ------
  always @(negedge clock) begin : mon
    psw_exp_t e;
    if (rst_n) begin
      chk("fetch in table", table_busy & pm_req, 1'b0);
      pm_n += int'(pm_req);
      dm_n += int'(dm_req);
      if (rd_done) begin
        chk("done owed", q.size() != 0, 1'b1);
        if (q.size() != 0) begin
          e = q.pop_front();
          chk("latency", cyc, e.due);
          chk("data", rd_data, e.data);
          chk("view hit", view_hit, e.view);
          chk("fetches", pm_n, e.npm);
          chk("data fetches", dm_n, 32'(!e.view));
          chk("busy at done", busy, 1'b0);
          if (e.view) begin
            chk("pm addr", pm_addr, e.addr);
          end else begin
            chk("dm addr", dm_addr, e.addr[15:0]);
          end
        end
        pm_n = 0;
        dm_n = 0;
      end
    end
  end

  // ------
  // Driver
  // ------
  task automatic rd(input logic [15:0] eff_addr, input psw_kind_t k, input logic [3:0] rp,
                    input logic en, input logic [7:0] pg, input int tw, input logic rf);
    psw_exp_t e;
    logic view;
    int x;
    rp[2:0] = rp[2:0] & {3{rp[3]}};
    @(negedge clock);
    while (busy !== 1'b0) @(negedge clock);
    view = en & eff_addr[15];
    x = !view ? 0 : !rp[3] ? (k == PSW_KIND_OTHER ? 2 : 1) : (|rp[2:0] ? 2 : 0);
    rd_req = 1'b1;
    rd_info = '{eff_addr, k, rp[3], rp[2], rp[1], rp[0]};
    cpu_control_reg = {13'($urandom()), en, 2'($urandom())};
    view_page_select = pg;
    table_busy = (tw > 0);
    e.view = view;
    e.addr = view ? {pg, eff_addr[14:0]} : {7'h0, eff_addr};
    e.data = view ? ({pg[0], eff_addr[14:0]} ^ {pg, 8'h5a}) : (eff_addr ^ 16'hc3a5);
    e.npm = view ? (x > 0 ? 2 : 1) : 0;
    e.due = cyc + 3 + x;
    @(negedge clock);
    rd_req = rf;
    rd_info.effective_address = 16'($urandom());
    if (tw > 0) begin
      repeat (tw - 1) @(negedge clock);
      table_busy = 1'b0;
      e.due = cyc + 3 + x;
    end
    q.push_back(e);
    if (rf) begin
      @(negedge clock);
      rd_req = 1'b0;
    end
  endtask

  initial begin
    rst_n = 1'b0;
    rd_req = 1'b0;
    rd_info = '0;
    cpu_control_reg = '0;
    view_page_select = '0;
    table_busy = 1'b0;
    void'($urandom(32'hb1ea7b0d));
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    for (int k = 0; k < 3; k++) rd(16'h8000 + 16'(k), psw_kind_t'(k), 4'h0, 1, 8'hff, 0, 0);
    // loop edges and middle, some with a refused request
    for (int r = 8; r < 16; r++) rd(16'hffff, PSW_KIND_OTHER, 4'(r), 1, 8'h00, 0, r[0]);
    rd(16'hffff, PSW_KIND_MOVE, 4'h0, 0, 8'h5a, 0, 1);
    rd(16'h7fff, PSW_KIND_OTHER, 4'h0, 1, 8'h5a, 0, 0);
    rd(16'hc000, PSW_KIND_DOUBLE_MOVE, 4'h0, 1, 8'h81, 5, 0);
    rd(16'h8002, PSW_KIND_MOVE, 4'h0, 1, 8'h01, 1, 0);
    for (int i = 0; i < 60; i++) begin
      rd(16'($urandom()), psw_kind_t'($urandom_range(2)), 4'($urandom()),
         1'($urandom()), 8'($urandom()), 0, 0);
    end
    repeat (12) @(negedge clock);
    chk("left owed", q.size(), 0);
    final_report();
  end
endmodule // program_space_data_window_tb
`default_nettype wire
